// ---- logic/instr_exec.sv ----
// instruction execution slice of a 4-bit controller core
`timescale 1ns/100ps
`default_nettype none
module instr_exec
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // instruction stream
    input  wire logic [8:0]  instr_in,
    input  wire logic        instr_valid_in,
    // register inputs from outside the slice
    input  wire logic [7:0]  reg_e_in,
    input  wire logic [1:0]  logic_op_select_in,
    // pins
    input  wire logic [2:0]  port_e_pins_in,
    input  wire logic [3:0]  port_g_pins_in,
    // state outputs
    output logic [3:0]       acc_out,
    output logic             carry_flag_out,
    output logic [1:0]       ram_pointer_x_out,
    output logic [3:0]       ram_pointer_y_out,
    output logic [3:0]       program_page_out,
    output logic [6:0]       program_low_counter_out,
    output logic [1:0]       stack_pointer_out,
    output logic             system_clock_select_out,
    output logic             skip_out,
    // port latches
    output logic [7:0]       port_d_out,
    output logic [7:0]       port_d_oe_n_out,
    output logic [1:0]       port_e_out,
    output logic [3:0]       port_g_out
);
    ram_bus_if ram ();

    nibble_ram u_ram
    (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .bus    (ram)
    );

    // pin synchronisers: three stages, change taken when stages 2 and 3 agree
    logic [6:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_q_r;
    logic [6:0] pin_q_nxt;
    always_comb
    begin
        pin_q_nxt = pin_q_r;
        for (int i = 0; i < 7; i++)
            if (pin_s2_r[i] == pin_s3_r[i])
                pin_q_nxt[i] = pin_s3_r[i];
    end
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pin_s1_r <= 7'h00;
            pin_s2_r <= 7'h00;
            pin_s3_r <= 7'h00;
            pin_q_r  <= 7'h00;
        end
        else
        begin
            pin_s1_r <= {port_g_pins_in, port_e_pins_in};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            pin_q_r  <= pin_q_nxt;
        end
    end

    // architectural state
    instr_exec_pkg::seq_state_e state_r, state_nxt;
    logic [3:0]  acc_r, acc_nxt;
    logic        cy_r, cy_nxt;
    logic [1:0]  px_r, px_nxt;
    logic [3:0]  py_r, py_nxt;
    logic [3:0]  page_r, page_nxt;
    logic [6:0]  pcl_r, pcl_nxt;
    logic [1:0]  sp_r, sp_nxt;
    logic        clk_sel_r, clk_sel_nxt;
    logic        skip_r, skip_nxt;
    logic        skip2_r, skip2_nxt;         // skip second word of a skipped call
    logic [1:0]  run_r, run_nxt;             // 1: last was load imm, 2: pointer load
    logic [8:0]  word1_r, word1_nxt;
    logic [7:0]  pd_r, pd_nxt;
    logic [1:0]  pe_r, pe_nxt;
    logic [3:0]  pg_r, pg_nxt;
    logic [7:0]  oe_n_r, oe_n_nxt;          // port d enables, low where driving
    logic [10:0] stk_r [instr_exec_pkg::STACK_DEPTH];
    logic [10:0] stk_nxt [instr_exec_pkg::STACK_DEPTH];
    logic [3:0]  logic_res;
    logic [8:0]  w;
    logic        two_word;

    // logic operation result
    always_comb
    begin
        case (logic_op_select_in)
            instr_exec_pkg::LOGIC_XOR: logic_res = acc_r ^ reg_e_in[3:0];
            instr_exec_pkg::LOGIC_OR:  logic_res = acc_r | reg_e_in[3:0];
            instr_exec_pkg::LOGIC_AND: logic_res = acc_r & reg_e_in[3:0];
            default:                   logic_res = acc_r;
        endcase
    end

    assign ram.addr  = {px_r, py_r};
    assign w         = instr_in;
    assign two_word  = (w[8:4] == instr_exec_pkg::OP_LONG_CALL[8:4]) ||
                       (w == instr_exec_pkg::OP_LONG_CALL_ACC);

    // next-state and execution
    always_comb
    begin
        state_nxt   = state_r;
        acc_nxt     = acc_r;
        cy_nxt      = cy_r;
        px_nxt      = px_r;
        py_nxt      = py_r;
        page_nxt    = page_r;
        pcl_nxt     = pcl_r;
        sp_nxt      = sp_r;
        clk_sel_nxt = clk_sel_r;
        skip_nxt    = skip_r;
        skip2_nxt   = skip2_r;
        run_nxt     = run_r;
        word1_nxt   = word1_r;
        pd_nxt      = pd_r;
        pe_nxt      = pe_r;
        pg_nxt      = pg_r;
        stk_nxt     = stk_r;
        ram.we      = 1'b0;
        ram.wdata   = ram.rdata;
        case (state_r)
            instr_exec_pkg::ST_RETURN:
            begin
                // second return cycle: pc reloaded from popped entry
                {page_nxt, pcl_nxt} = stk_r[sp_r + 2'h1];
                state_nxt = instr_exec_pkg::ST_EXEC;
            end
            instr_exec_pkg::ST_WORD2:
            begin
                if (instr_valid_in)
                begin
                    // second word completes the call
                    state_nxt = instr_exec_pkg::ST_EXEC;
                    sp_nxt = sp_r + 2'h1;
                    stk_nxt[sp_r + 2'h1] = {page_r, pcl_r};
                    if (word1_r[8:4] == instr_exec_pkg::OP_LONG_CALL[8:4])
                    begin
                        page_nxt = word1_r[3:0];
                        pcl_nxt = w[6:0];
                    end
                    else
                    begin
                        page_nxt = w[3:0];
                        pcl_nxt = {w[6:4], acc_r};
                    end
                end
            end
            default:
            begin
                if (instr_valid_in)
                begin
                    run_nxt = 2'h0;
                    if (skip2_r)
                        skip2_nxt = 1'b0;
                    else if (skip_r)
                    begin
                        // fetched without effect except on the run and skip2 tracking
                        skip_nxt = 1'b0;
                        skip2_nxt = two_word;
                        if (w[8:4] == instr_exec_pkg::OP_LOAD_IMM_HI)
                            run_nxt = 2'h1;
                        if (w[8:6] == instr_exec_pkg::OP_PTR_LOAD_HI)
                            run_nxt = 2'h2;
                    end
                    else if (two_word)
                    begin
                        word1_nxt = w;
                        state_nxt = instr_exec_pkg::ST_WORD2;
                    end
                    else if (w[8:4] == instr_exec_pkg::OP_LOAD_IMM_HI)
                    begin
                        if (run_r != 2'h1)
                            acc_nxt = w[3:0];
                        run_nxt = 2'h1;
                    end
                    else if (w[8:6] == instr_exec_pkg::OP_PTR_LOAD_HI)
                    begin
                        if (run_r != 2'h2)
                        begin
                            px_nxt = w[5:4];
                            py_nxt = w[3:0];
                        end
                        run_nxt = 2'h2;
                    end
                    else if (w[8:2] == instr_exec_pkg::OP_BIT_CLR_HI)
                    begin
                        ram.we = 1'b1;
                        ram.wdata = ram.rdata & ~(4'h1 << w[1:0]);
                    end
                    else if (w[8:2] == instr_exec_pkg::OP_BIT_SET_HI)
                    begin
                        ram.we = 1'b1;
                        ram.wdata = ram.rdata | (4'h1 << w[1:0]);
                    end
                    else
                    begin
                        case (w)
                            instr_exec_pkg::OP_CLOCK_SWITCH:
                                clk_sel_nxt = 1'b1;
                            instr_exec_pkg::OP_PORT_D_CLR:
                                pd_nxt = instr_exec_pkg::PORT_D_RESET;
                            instr_exec_pkg::OP_PTR_DEC:
                            begin
                                py_nxt = py_r - 4'h1;
                                skip_nxt = (py_r - 4'h1) == instr_exec_pkg::PTR_WRAP_DEC;
                            end
                            instr_exec_pkg::OP_PTR_INC:
                            begin
                                py_nxt = py_r + 4'h1;
                                skip_nxt = (py_r + 4'h1) == instr_exec_pkg::PTR_WRAP_INC;
                            end
                            instr_exec_pkg::OP_PORT_E_IN:
                                acc_nxt[2:0] = pin_q_r[2:0];
                            instr_exec_pkg::OP_PORT_G_IN:
                                acc_nxt = pin_q_r[6:3];
                            instr_exec_pkg::OP_LOGIC_OP:
                                acc_nxt = logic_res;
                            instr_exec_pkg::OP_PORT_E_OUT:
                                pe_nxt = acc_r[1:0];
                            instr_exec_pkg::OP_PORT_G_OUT:
                                pg_nxt = acc_r;
                            instr_exec_pkg::OP_ROTATE:
                            begin
                                acc_nxt = {cy_r, acc_r[3:1]};
                                cy_nxt = acc_r[0];
                            end
                            instr_exec_pkg::OP_PORT_D_BITCLR:
                                if (!py_r[3])
                                    pd_nxt[py_r[2:0]] = 1'b0;
                            instr_exec_pkg::OP_RETURN:
                            begin
                                sp_nxt = sp_r - 2'h1;
                                state_nxt = instr_exec_pkg::ST_RETURN;
                            end
                            instr_exec_pkg::OP_RETURN_SKIP:
                            begin
                                sp_nxt = sp_r - 2'h1;
                                skip_nxt = 1'b1;
                                state_nxt = instr_exec_pkg::ST_RETURN;
                            end
                            default:
                                pcl_nxt = pcl_r;
                        endcase
                    end
                end
            end
        endcase
        oe_n_nxt = ~pd_nxt;
    end

    // state registers
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state_r   <= instr_exec_pkg::ST_EXEC;
            acc_r     <= instr_exec_pkg::ACC_RESET;
            cy_r      <= 1'b0;
            px_r      <= 2'h0;
            py_r      <= 4'h0;
            page_r    <= 4'h0;
            pcl_r     <= 7'h00;
            sp_r      <= instr_exec_pkg::STACK_PTR_RESET;
            clk_sel_r <= 1'b0;
            skip_r    <= 1'b0;
            skip2_r   <= 1'b0;
            run_r     <= 2'h0;
            word1_r   <= 9'h000;
            pd_r      <= instr_exec_pkg::PORT_D_RESET;
            pe_r      <= 2'h0;
            pg_r      <= 4'h0;
            oe_n_r    <= ~instr_exec_pkg::PORT_D_RESET;
            for (int i = 0; i < instr_exec_pkg::STACK_DEPTH; i++)
                stk_r[i] <= 11'h000;
        end
        else
        begin
            state_r   <= state_nxt;
            acc_r     <= acc_nxt;
            cy_r      <= cy_nxt;
            px_r      <= px_nxt;
            py_r      <= py_nxt;
            page_r    <= page_nxt;
            pcl_r     <= pcl_nxt;
            sp_r      <= sp_nxt;
            clk_sel_r <= clk_sel_nxt;
            skip_r    <= skip_nxt;
            skip2_r   <= skip2_nxt;
            run_r     <= run_nxt;
            word1_r   <= word1_nxt;
            pd_r      <= pd_nxt;
            pe_r      <= pe_nxt;
            pg_r      <= pg_nxt;
            oe_n_r    <= oe_n_nxt;
            stk_r     <= stk_nxt;
        end
    end

    // outputs straight from flip-flops
    assign acc_out                 = acc_r;
    assign carry_flag_out          = cy_r;
    assign ram_pointer_x_out       = px_r;
    assign ram_pointer_y_out       = py_r;
    assign program_page_out        = page_r;
    assign program_low_counter_out = pcl_r;
    assign stack_pointer_out       = sp_r;
    assign system_clock_select_out = clk_sel_r;
    assign skip_out                = skip_r;
    assign port_d_out              = pd_r;
    assign port_d_oe_n_out         = oe_n_r;  // latch 1 drives, 0 floats
    assign port_e_out              = pe_r;
    assign port_g_out              = pg_r;
endmodule : instr_exec
`default_nettype wire

// ---- logic/instr_exec_pkg.sv ----
// constants and types shared by the instruction execution slice
package instr_exec_pkg;
    // opcode values (9-bit words)
    localparam logic [8:0] OP_LONG_CALL     = 9'h070;
    localparam logic [8:0] OP_LONG_CALL_ACC = 9'h050;
    localparam logic [8:0] OP_CLOCK_SWITCH  = 9'h059;
    localparam logic [8:0] OP_PORT_D_CLR    = 9'h011;
    localparam logic [8:0] OP_PTR_DEC       = 9'h017;
    localparam logic [8:0] OP_PTR_INC       = 9'h013;
    localparam logic [8:0] OP_PORT_E_IN     = 9'h056;
    localparam logic [8:0] OP_PORT_G_IN     = 9'h028;
    localparam logic [8:0] OP_LOGIC_OP      = 9'h041;
    localparam logic [8:0] OP_PORT_E_OUT    = 9'h084;
    localparam logic [8:0] OP_PORT_G_OUT    = 9'h080;
    localparam logic [8:0] OP_ROTATE        = 9'h01d;
    localparam logic [8:0] OP_PORT_D_BITCLR = 9'h014;
    localparam logic [8:0] OP_RETURN        = 9'h044;
    localparam logic [8:0] OP_RETURN_SKIP   = 9'h045;
    // opcode classes matched on upper bits
    localparam logic [4:0] OP_LOAD_IMM_HI   = 5'h0b;   // bits 8:4
    localparam logic [2:0] OP_PTR_LOAD_HI   = 3'h3;    // bits 8:6
    localparam logic [6:0] OP_BIT_CLR_HI    = 7'h13;   // bits 8:2
    localparam logic [6:0] OP_BIT_SET_HI    = 7'h17;   // bits 8:2
    localparam logic [1:0] SECOND_WORD_HI   = 2'h2;    // bits 8:7 of call word 2
    // logic operation select codes
    localparam logic [1:0] LOGIC_XOR        = 2'h0;
    localparam logic [1:0] LOGIC_OR         = 2'h1;
    localparam logic [1:0] LOGIC_AND        = 2'h2;
    // sizes
    localparam int STACK_DEPTH              = 4;
    localparam int RAM_WORDS                = 64;
    // reset values and pointer wrap values
    localparam logic [3:0] ACC_RESET        = 4'h0;
    localparam logic [7:0] PORT_D_RESET     = 8'h00;
    localparam logic [1:0] STACK_PTR_RESET  = 2'h3;
    localparam logic [3:0] PTR_WRAP_DEC     = 4'hf;
    localparam logic [3:0] PTR_WRAP_INC     = 4'h0;
    // sequencer states, gray along the call path
    typedef enum logic [1:0]
    {
        ST_EXEC   = 2'b00,
        ST_WORD2  = 2'b01,
        ST_RETURN = 2'b11
    } seq_state_e;
endpackage : instr_exec_pkg

// ---- logic/nibble_ram.sv ----
// 64 x 4 data memory held in flip-flops
`timescale 1ns/100ps
`default_nettype none
module nibble_ram
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // access port
    ram_bus_if.slave  bus
);
    logic [3:0] mem_r [instr_exec_pkg::RAM_WORDS];
    logic [3:0] mem_nxt [instr_exec_pkg::RAM_WORDS];

    // next contents per entry
    genvar gi;
    generate
        for (gi = 0; gi < instr_exec_pkg::RAM_WORDS; gi++)
        begin : g_word
            always_comb
            begin
                mem_nxt[gi] = mem_r[gi];
                if (bus.we && (bus.addr == 6'(gi)))
                    mem_nxt[gi] = bus.wdata;
            end
            always_ff @(posedge clk_in)
            begin
                if (rst_in)
                    mem_r[gi] <= 4'h0;
                else
                    mem_r[gi] <= mem_nxt[gi];
            end
        end
    endgenerate

    // combinational read
    assign bus.rdata = mem_r[bus.addr];
endmodule : nibble_ram
`default_nettype wire

// ---- logic/ram_bus_if.sv ----
// ram access bundle between the executor and its nibble store
`timescale 1ns/100ps
`default_nettype none
interface ram_bus_if;
    logic [5:0] addr;
    logic [3:0] wdata;
    logic       we;
    logic [3:0] rdata;
    modport master (output addr, output wdata, output we, input rdata);
    modport slave  (input addr, input wdata, input we, output rdata);
endinterface : ram_bus_if
`default_nettype wire

// ---- verif/instr_exec_assertions.sv ----
// port-level checker for the instruction execution slice
`timescale 1ns/100ps
`default_nettype none
module instr_exec_assertions
(
    // clock, reset and instruction stream
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic [8:0] instr_in,
    input wire logic       instr_valid_in,
    // state and latches
    input wire logic [3:0] acc_out,
    input wire logic       carry_flag_out,
    input wire logic [3:0] ram_pointer_y_out,
    input wire logic       system_clock_select_out,
    input wire logic       skip_out,
    input wire logic [7:0] port_d_out,
    input wire logic [7:0] port_d_oe_n_out,
    input wire logic [1:0] port_e_out,
    input wire logic [3:0] port_g_out
);
    logic w2_r;  // next taken word is the second word of a call
    logic go;    // a word that is not call word 2 is taken and not skipped
    // track call pairing so call word 2 is not read as an opcode
    always_ff @(posedge clk_in)
        if (rst_in)
            w2_r <= 1'b0;
        else if (instr_valid_in)
            w2_r <= !w2_r && (instr_in[8:4] == 5'h07 || instr_in == 9'h050);
    assign go = instr_valid_in && !skip_out && !w2_r;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_clock_switch;
        go && instr_in == instr_exec_pkg::OP_CLOCK_SWITCH |=> system_clock_select_out;
    endproperty
    a_clock_switch: assert property (p_clock_switch)
        else $error("clock select not set");
    property p_clock_hold;
        system_clock_select_out |=> system_clock_select_out;
    endproperty
    a_clock_hold: assert property (p_clock_hold)
        else $error("clock select fell");
    property p_port_g;
        go && instr_in == instr_exec_pkg::OP_PORT_G_OUT |=> port_g_out == $past(acc_out);
    endproperty
    a_port_g: assert property (p_port_g)
        else $error("port g not from acc");
    property p_port_e;
        go && instr_in == instr_exec_pkg::OP_PORT_E_OUT |=> port_e_out == $past(acc_out[1:0]);
    endproperty
    a_port_e: assert property (p_port_e)
        else $error("port e not from acc");
    property p_port_d_clear;
        go && instr_in == instr_exec_pkg::OP_PORT_D_CLR |=> port_d_out == 8'h00;
    endproperty
    a_port_d_clear: assert property (p_port_d_clear)
        else $error("port d not cleared");
    property p_float;
        port_d_oe_n_out == ~port_d_out;
    endproperty
    a_float: assert property (p_float)
        else $error("port d enable mismatch");
    property p_rotate;
        go && instr_in == instr_exec_pkg::OP_ROTATE |=>
            acc_out == {$past(carry_flag_out), $past(acc_out[3:1])}
            && carry_flag_out == $past(acc_out[0]);
    endproperty
    a_rotate: assert property (p_rotate)
        else $error("rotate wrong");
    property p_inc;
        go && instr_in == instr_exec_pkg::OP_PTR_INC |=>
            ram_pointer_y_out == $past(ram_pointer_y_out) + 4'h1
            && skip_out == (ram_pointer_y_out == 4'h0);
    endproperty
    a_inc: assert property (p_inc)
        else $error("increment or its skip wrong");
    property p_dec;
        go && instr_in == instr_exec_pkg::OP_PTR_DEC |=>
            ram_pointer_y_out == $past(ram_pointer_y_out) - 4'h1
            && skip_out == (ram_pointer_y_out == 4'hf);
    endproperty
    a_dec: assert property (p_dec)
        else $error("decrement or its skip wrong");
    property p_skip_quiet;
        skip_out && instr_valid_in |=> $stable(acc_out) && $stable(carry_flag_out)
            && $stable(ram_pointer_y_out) && $stable(port_g_out) && $stable(port_e_out);
    endproperty
    a_skip_quiet: assert property (p_skip_quiet)
        else $error("skipped word changed state");
endmodule : instr_exec_assertions
bind instr_exec instr_exec_assertions chk_u (.clk_in(clk_in), .rst_in(rst_in),
    .instr_in(instr_in), .instr_valid_in(instr_valid_in), .acc_out(acc_out),
    .carry_flag_out(carry_flag_out), .ram_pointer_y_out(ram_pointer_y_out),
    .system_clock_select_out(system_clock_select_out), .skip_out(skip_out),
    .port_d_out(port_d_out), .port_d_oe_n_out(port_d_oe_n_out),
    .port_e_out(port_e_out), .port_g_out(port_g_out));
`default_nettype wire

// ---- verif/nibble_cpu_instr_exec_subset_tb.sv ----
// self-checking bench for the instruction execution slice
`timescale 1ns/100ps
`default_nettype none
module nibble_cpu_instr_exec_subset_tb;
    logic clk_in, rst_in, instr_valid_in, clk_sel, skip;
    logic [8:0] instr_in;
    logic [7:0] reg_e_in, port_d, port_d_oe_n;
    logic [1:0] sel, x_ptr, sp, port_e;
    logic [2:0] e_pins;
    logic [3:0] g_pins, acc, y_ptr, page, port_g;
    logic [6:0] program_low_counter;
    logic       carry;
    int         fails, checks_done, cycles;
    instr_exec dut_u (.clk_in(clk_in), .rst_in(rst_in), .instr_in(instr_in),
        .instr_valid_in(instr_valid_in), .reg_e_in(reg_e_in), .logic_op_select_in(sel),
        .port_e_pins_in(e_pins), .port_g_pins_in(g_pins), .acc_out(acc),
        .carry_flag_out(carry), .ram_pointer_x_out(x_ptr), .ram_pointer_y_out(y_ptr),
        .program_page_out(page), .program_low_counter_out(program_low_counter), .stack_pointer_out(sp),
        .system_clock_select_out(clk_sel), .skip_out(skip), .port_d_out(port_d),
        .port_d_oe_n_out(port_d_oe_n), .port_e_out(port_e), .port_g_out(port_g));
    // clock generation
    initial
    begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // hang guard
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles > 2000)
        begin
            fails++;
            end_of_test();
        end
    end
    // present one word for one taking edge
    task automatic send(input logic [8:0] w);
        @(negedge clk_in);
        instr_in = w;
        instr_valid_in = 1'b1;
    endtask : send
    task automatic idle(input int n);
        repeat (n)
        begin
            @(negedge clk_in);
            instr_valid_in = 1'b0;
        end
    endtask : idle
    task automatic exec(input logic [8:0] w);
        send(w);
        idle(2);
    endtask : exec
    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    // word builders
    function automatic logic [8:0] lim(input logic [3:0] n);
        return {instr_exec_pkg::OP_LOAD_IMM_HI, n};
    endfunction : lim
    function automatic logic [8:0] pld(input logic [1:0] x, input logic [3:0] y);
        return {instr_exec_pkg::OP_PTR_LOAD_HI, x, y};
    endfunction : pld
    // main sequence
    initial
    begin
        logic [3:0] exp;
        {instr_in, instr_valid_in, sel, e_pins, g_pins} = '0;
        reg_e_in = 8'h56;
        rst_in = 1'b1;
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        check_val("sp reset", 8'h03, 8'(sp));
        check_val("oe reset", 8'hff, port_d_oe_n);
        send(lim(4'h5));
        send(lim(4'h9));
        idle(2);
        check_val("imm run", 8'h05, 8'(acc));
        exec(instr_exec_pkg::OP_CLOCK_SWITCH);
        check_val("clk sel", 8'h01, 8'(clk_sel));
        for (int s = 0; s < 4; s++)
        begin
            sel = 2'(s);
            exec(lim(4'ha));
            exec(instr_exec_pkg::OP_LOGIC_OP);
            exp = (s == 0) ? 4'hc : (s == 1) ? 4'he : (s == 2) ? 4'h2 : 4'ha;
            check_val("logic op", 8'(exp), 8'(acc));
        end
        exec(lim(4'h5));
        exec(instr_exec_pkg::OP_ROTATE);
        check_val("rot acc", 8'h12, {3'h0, carry, acc});
        exec(instr_exec_pkg::OP_ROTATE);
        check_val("rot acc2", 8'h09, {3'h0, carry, acc});
        exec(lim(4'h6));
        exec(instr_exec_pkg::OP_PORT_E_OUT);
        exec(instr_exec_pkg::OP_PORT_G_OUT);
        check_val("port e", 8'h02, 8'(port_e));
        check_val("port g", 8'h06, 8'(port_g));
        e_pins = 3'h5;
        g_pins = 4'h9;
        exec(lim(4'h8));
        idle(6);
        exec(instr_exec_pkg::OP_PORT_E_IN);
        check_val("in e", 8'h0d, 8'(acc));
        exec(instr_exec_pkg::OP_PORT_G_IN);
        check_val("in g", 8'h09, 8'(acc));
        send(pld(2'h2, 4'h7));
        send(pld(2'h1, 4'h3));
        idle(2);
        check_val("ptr run", 8'h27, {2'h0, x_ptr, y_ptr});
        exec(instr_exec_pkg::OP_PORT_D_CLR);
        check_val("port d", 8'h00, port_d);
        exec(instr_exec_pkg::OP_PORT_D_BITCLR);
        check_val("port d bit oe", 8'hff, port_d_oe_n);
        exec({instr_exec_pkg::OP_BIT_SET_HI, 2'h1});
        exec({instr_exec_pkg::OP_BIT_CLR_HI, 2'h1});
        exec(pld(2'h1, 4'h0));
        exec(instr_exec_pkg::OP_PTR_DEC);
        check_val("dec", 8'h1f, {3'h0, skip, y_ptr});
        exec(instr_exec_pkg::OP_PTR_INC);
        check_val("skipped inc", 8'h0f, {3'h0, skip, y_ptr});
        exec(instr_exec_pkg::OP_PTR_INC);
        check_val("inc", 8'h10, {3'h0, skip, y_ptr});
        send(instr_exec_pkg::OP_LONG_CALL | 9'h003);
        send({instr_exec_pkg::SECOND_WORD_HI, 7'h11});
        idle(2);
        check_val("skipped call", 8'h30, {2'h0, sp, page});
        exec(lim(4'h3));
        check_val("after skip", 8'h03, 8'(acc));
        send(instr_exec_pkg::OP_LONG_CALL | 9'h005);
        send({instr_exec_pkg::SECOND_WORD_HI, 7'h2a});
        idle(2);
        check_val("call sp page", 8'h05, {2'h0, sp, page});
        check_val("call low", 8'h2a, 8'(program_low_counter));
        send(instr_exec_pkg::OP_LONG_CALL_ACC);
        send({instr_exec_pkg::SECOND_WORD_HI, 3'h6, 4'h9});
        idle(2);
        check_val("acall sp page", 8'h19, {2'h0, sp, page});
        check_val("acall low", 8'h63, 8'(program_low_counter));
        send(instr_exec_pkg::OP_RETURN);
        idle(3);
        check_val("ret sp page", 8'h05, {2'h0, sp, page});
        check_val("ret low", 8'h2a, 8'(program_low_counter));
        send(instr_exec_pkg::OP_RETURN_SKIP);
        idle(3);
        check_val("rets sp page", 8'h30, {2'h0, sp, page});
        check_val("rets skip", 8'h01, 8'(skip));
        exec(instr_exec_pkg::OP_PTR_INC);
        check_val("rets skipped", 8'h00, {3'h0, skip, y_ptr});
        end_of_test();
    end
endmodule : nibble_cpu_instr_exec_subset_tb
`default_nettype wire
